// ### logic/scp_pkg.sv
package scp_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int NPORT  = 2;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int DIV_W  = 8;
    localparam int DEB_W  = 16;
    localparam int EV_PER_PORT = 3;
    localparam int INT_W  = EV_PER_PORT * NPORT;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] PORT_STRIDE   = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_DIV       = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_CTRL      = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_STAT      = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_INT_STAT = 8'h20;
    localparam logic [ADDR_W-1:0] ADDR_INT_MASK = 8'h24;
    localparam logic [ADDR_W-1:0] ADDR_CFG      = 8'h28;

    // Field positions
    localparam int CTRL_CLK_EN    = 0;
    localparam int CTRL_DDR       = 1;
    localparam int CTRL_READ_WAIT = 2;
    localparam int CTRL_SDIO_IRQ  = 3;
    localparam int CTRL_GRADE_LSB = 4;
    localparam int STAT_DAT3      = 0;
    localparam int STAT_SWITCH    = 1;
    localparam int STAT_WP        = 2;
    localparam int STAT_CLK_RUN   = 3;
    localparam int STAT_GRADE_REJ = 4;
    localparam int STAT_DAT1      = 5;
    localparam int CFG_REF_LSB    = 0;
    localparam int CFG_OWNER      = 2;
    localparam int EV_DAT3        = 0;
    localparam int EV_SWITCH      = 1;
    localparam int EV_SDIO        = 2;

    // Encodings
    localparam logic [1:0] REF_19M2  = 2'h0;
    localparam logic [1:0] REF_26M   = 2'h1;
    localparam logic [1:0] REF_38M4  = 2'h2;
    localparam logic [1:0] REF_52M   = 2'h3;
    localparam logic [1:0] GRADE_DIV = 2'h0;
    localparam logic [1:0] GRADE_48  = 2'h1;
    localparam logic [1:0] GRADE_52  = 2'h2;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CORE_HZ     = 100_000_000;
    localparam int INIT_HZ     = 400_000;
    localparam int G48_HZ      = 48_000_000;
    localparam int G52_HZ      = 52_000_000;
    localparam int DDR_MAX_HZ  = 52_000_000;
    localparam int DEB_TIME_US = 100;
    // Half period is div+1 core cycles; rounding up never exceeds the target
    localparam logic [DIV_W-1:0] INIT_DIV = DIV_W'(CORE_HZ / (2 * INIT_HZ) - 1);
    localparam logic [DIV_W-1:0] DIV_G48 =
        DIV_W'((CORE_HZ + 2 * G48_HZ - 1) / (2 * G48_HZ) - 1);
    localparam logic [DIV_W-1:0] DIV_G52 =
        DIV_W'((CORE_HZ + 2 * G52_HZ - 1) / (2 * G52_HZ) - 1);
    localparam logic [DIV_W-1:0] DDR_MIN_DIV =
        DIV_W'((CORE_HZ + 2 * DDR_MAX_HZ - 1) / (2 * DDR_MAX_HZ) - 1);
    localparam int DEB_CYCLES_DEF = DEB_TIME_US * (CORE_HZ / 1_000_000);

    // Reset values
    localparam logic [INT_W-1:0] RST_INT_MASK = 6'h00;
    localparam logic [1:0]       RST_REF      = REF_19M2;

    // ------------------------------------------------------------------
    // Carriers and state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } scp_apb_req_t;

    typedef struct packed {
        logic [DATA_W-1:0] prdata;
        logic              pready;
        logic              pslverr;
    } scp_apb_rsp_t;

    typedef struct packed {
        logic dat3;
        logic wp;
        logic dat1;
    } scp_card_in_t;

    typedef struct packed {
        logic [DIV_W-1:0] div;
        logic [1:0]       grade;
        logic             clkEn;
        logic             ddr;
        logic             readWait;
        logic             sdioIrqEn;
        logic [DIV_W-1:0] divCnt;
        logic             clkLvl;
        logic             strobe;
        scp_card_in_t     syncA;
        scp_card_in_t     syncB;
        logic             dat3Deb;
        logic             wpDeb;
        logic [DEB_W-1:0] dat3Cnt;
        logic [DEB_W-1:0] wpCnt;
    } scp_port_t;

    typedef struct packed {
        scp_port_t [NPORT-1:0] port;
        logic                  insA;
        logic                  insB;
        logic                  insDeb;
        logic [DEB_W-1:0]      insCnt;
        logic                  owner;
        logic [1:0]            refSel;
        logic [INT_W-1:0]      intStat;
        logic [INT_W-1:0]      intMask;
        logic [DATA_W-1:0]     prdata;
        logic                  irq;
    } scp_state_t;

endpackage : scp_pkg

// ### logic/scp_storage_port.sv
`timescale 1ns/10ps

module scp_storage_port #(
    parameter int DEB_CYCLES = scp_pkg::DEB_CYCLES_DEF
) (
    input  wire logic                                 core_clk,
    input  wire logic                                 arst_n,
    input  wire scp_pkg::scp_apb_req_t                apbReq,
    output      scp_pkg::scp_apb_rsp_t                apbRsp,
    input  wire scp_pkg::scp_card_in_t [scp_pkg::NPORT-1:0] cardIn,
    input  wire logic                                 cardInsertSwitch,
    input  wire logic [scp_pkg::NPORT-1:0]            rxBufFull,
    output      logic [scp_pkg::NPORT-1:0]            cardClockOut,
    output      logic [scp_pkg::NPORT-1:0]            dataStrobe,
    output      logic [scp_pkg::NPORT-1:0]            ddrMode,
    output      logic [scp_pkg::NPORT-1:0]            dat2Out,
    output      logic [scp_pkg::NPORT-1:0]            dat2Oe,
    output      logic [scp_pkg::NPORT-1:0]            wpGpio,
    output      logic                                 irq
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    localparam logic [scp_pkg::DEB_W-1:0] DEB_LIM = scp_pkg::DEB_W'(DEB_CYCLES - 1);

    // Returns {level, count}: level follows raw only after a stable run
    function automatic logic [scp_pkg::DEB_W:0] debounce(
        input logic                      raw,
        input logic                      lvl,
        input logic [scp_pkg::DEB_W-1:0] cnt
    );
        logic [scp_pkg::DEB_W:0] res;
        if (raw == lvl) begin
            res = {lvl, {scp_pkg::DEB_W{1'b0}}};
        end else if (cnt >= DEB_LIM) begin
            res = {raw, {scp_pkg::DEB_W{1'b0}}};
        end else begin
            res = {lvl, scp_pkg::DEB_W'(cnt + 1'b1)};
        end
        return res;
    endfunction : debounce

    // Returns {rejected, divisor} for the selected grade
    function automatic logic [scp_pkg::DIV_W:0] effDivisor(
        input scp_pkg::scp_port_t pt,
        input logic [1:0]         refSel
    );
        logic                      ok48;
        logic                      ok52;
        logic                      rej;
        logic [scp_pkg::DIV_W-1:0] d;
        ok48 = (refSel == scp_pkg::REF_19M2) || (refSel == scp_pkg::REF_38M4);
        ok52 = (refSel == scp_pkg::REF_26M) || (refSel == scp_pkg::REF_52M);
        rej  = 1'b0;
        d    = pt.div;
        case (pt.grade)
            scp_pkg::GRADE_48: begin
                if (ok48) d = scp_pkg::DIV_G48;
                else rej = 1'b1;
            end
            scp_pkg::GRADE_52: begin
                if (ok52) d = scp_pkg::DIV_G52;
                else rej = 1'b1;
            end
            default: begin
                d = pt.div;
            end
        endcase
        // DDR may never run faster than its ceiling
        if (pt.ddr && d < scp_pkg::DDR_MIN_DIV) d = scp_pkg::DDR_MIN_DIV;
        return {rej, d};
    endfunction : effDivisor

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    scp_pkg::scp_state_t     q_ff;
    scp_pkg::scp_state_t     nxt_q;
    logic [scp_pkg::NPORT-1:0] gradeRej;
    logic [scp_pkg::NPORT-1:0] clkRun;
    logic                      apbSetup;
    logic                      apbWrite;
    logic                      apbHit;
    logic                      portSpace;
    logic                      portSel;
    logic [3:0]                regOff;

    always_comb begin
        logic [scp_pkg::INT_W-1:0]  evSet;
        logic [scp_pkg::INT_W-1:0]  evClr;
        logic [scp_pkg::DEB_W:0]    db;
        logic [scp_pkg::DIV_W:0]    ed;
        logic [scp_pkg::DATA_W-1:0] rdVal;
        logic [scp_pkg::DATA_W-1:0] wd;
        scp_pkg::scp_port_t         rp;
        evSet  = '0;
        evClr  = '0;
        db     = '0;
        ed     = '0;
        rdVal  = '0;
        rp     = '0;
        wd     = apbReq.pwdata;
        nxt_q  = q_ff;
        gradeRej = '0;
        clkRun   = '0;

        // --------------------------------------------------------------
        // Bus decode: registers answer with no wait states
        // --------------------------------------------------------------
        apbSetup  = apbReq.psel && !apbReq.penable;
        apbWrite  = apbReq.psel && apbReq.penable && apbReq.pwrite;
        portSpace = (apbReq.paddr[scp_pkg::ADDR_W-1:5] == 3'h0);
        portSel   = apbReq.paddr[4];
        regOff    = apbReq.paddr[3:0];
        apbHit    = (portSpace && (regOff == scp_pkg::OFF_DIV[3:0]
                                || regOff == scp_pkg::OFF_CTRL[3:0]
                                || regOff == scp_pkg::OFF_STAT[3:0]))
                 || apbReq.paddr == scp_pkg::ADDR_INT_STAT
                 || apbReq.paddr == scp_pkg::ADDR_INT_MASK
                 || apbReq.paddr == scp_pkg::ADDR_CFG;

        // Shared insert switch, one synchroniser and filter for both ports
        nxt_q.insA   = cardInsertSwitch;
        nxt_q.insB   = q_ff.insA;
        db           = debounce(q_ff.insB, q_ff.insDeb, q_ff.insCnt);
        nxt_q.insDeb = db[scp_pkg::DEB_W];
        nxt_q.insCnt = db[scp_pkg::DEB_W-1:0];

        // --------------------------------------------------------------
        // Per-port logic, identical for every port
        // --------------------------------------------------------------
        for (int p = 0; p < scp_pkg::NPORT; p++) begin
            nxt_q.port[p].syncA = cardIn[p];
            nxt_q.port[p].syncB = q_ff.port[p].syncA;

            db = debounce(q_ff.port[p].syncB.dat3, q_ff.port[p].dat3Deb,
                          q_ff.port[p].dat3Cnt);
            nxt_q.port[p].dat3Deb = db[scp_pkg::DEB_W];
            nxt_q.port[p].dat3Cnt = db[scp_pkg::DEB_W-1:0];
            db = debounce(q_ff.port[p].syncB.wp, q_ff.port[p].wpDeb,
                          q_ff.port[p].wpCnt);
            nxt_q.port[p].wpDeb = db[scp_pkg::DEB_W];
            nxt_q.port[p].wpCnt = db[scp_pkg::DEB_W-1:0];

            if (nxt_q.port[p].dat3Deb != q_ff.port[p].dat3Deb) begin
                evSet[p * scp_pkg::EV_PER_PORT + scp_pkg::EV_DAT3] = 1'b1;
            end
            if (q_ff.owner == 1'(p) && nxt_q.insDeb != q_ff.insDeb) begin
                evSet[p * scp_pkg::EV_PER_PORT + scp_pkg::EV_SWITCH] = 1'b1;
            end
            // Card pulls data line 1 low to signal an interrupt
            // Level-sensitive: software must disable it while data moves on line 1
            if (q_ff.port[p].sdioIrqEn && !q_ff.port[p].syncB.dat1) begin
                evSet[p * scp_pkg::EV_PER_PORT + scp_pkg::EV_SDIO] = 1'b1;
            end

            // Card clock: stops only in its low phase so no runt pulse reaches the card
            ed          = effDivisor(q_ff.port[p], q_ff.refSel);
            gradeRej[p] = ed[scp_pkg::DIV_W];
            clkRun[p]   = q_ff.port[p].clkEn && !rxBufFull[p];
            nxt_q.port[p].strobe = 1'b0;
            if (q_ff.port[p].divCnt >= ed[scp_pkg::DIV_W-1:0]) begin
                nxt_q.port[p].divCnt = '0;
                if (q_ff.port[p].clkLvl) begin
                    nxt_q.port[p].clkLvl = 1'b0;
                    nxt_q.port[p].strobe = q_ff.port[p].ddr;
                end else if (clkRun[p]) begin
                    nxt_q.port[p].clkLvl = 1'b1;
                    nxt_q.port[p].strobe = 1'b1;
                end
            end else begin
                nxt_q.port[p].divCnt = scp_pkg::DIV_W'(q_ff.port[p].divCnt + 1'b1);
            end

            if (apbWrite && portSpace && portSel == 1'(p)) begin
                if (regOff == scp_pkg::OFF_DIV[3:0]) begin
                    nxt_q.port[p].div = wd[scp_pkg::DIV_W-1:0];
                end
                if (regOff == scp_pkg::OFF_CTRL[3:0]) begin
                    nxt_q.port[p].clkEn     = wd[scp_pkg::CTRL_CLK_EN];
                    nxt_q.port[p].ddr       = wd[scp_pkg::CTRL_DDR];
                    nxt_q.port[p].readWait  = wd[scp_pkg::CTRL_READ_WAIT];
                    nxt_q.port[p].sdioIrqEn = wd[scp_pkg::CTRL_SDIO_IRQ];
                    nxt_q.port[p].grade     = wd[scp_pkg::CTRL_GRADE_LSB +: 2];
                end
            end
        end

        // --------------------------------------------------------------
        // Global registers
        // --------------------------------------------------------------
        if (apbWrite && apbReq.paddr == scp_pkg::ADDR_INT_STAT) begin
            evClr = wd[scp_pkg::INT_W-1:0];
        end
        if (apbWrite && apbReq.paddr == scp_pkg::ADDR_INT_MASK) begin
            nxt_q.intMask = wd[scp_pkg::INT_W-1:0];
        end
        if (apbWrite && apbReq.paddr == scp_pkg::ADDR_CFG) begin
            nxt_q.refSel = wd[scp_pkg::CFG_REF_LSB +: 2];
            nxt_q.owner  = wd[scp_pkg::CFG_OWNER];
        end
        // A new event in the clearing cycle survives the clear
        nxt_q.intStat = (q_ff.intStat & ~evClr) | evSet;
        nxt_q.irq     = |(nxt_q.intStat & nxt_q.intMask);

        // Read data is captured in the setup cycle
        rp = q_ff.port[portSel];
        if (portSpace && regOff == scp_pkg::OFF_DIV[3:0]) begin
            rdVal[scp_pkg::DIV_W-1:0] = rp.div;
        end else if (portSpace && regOff == scp_pkg::OFF_CTRL[3:0]) begin
            rdVal[scp_pkg::CTRL_CLK_EN]         = rp.clkEn;
            rdVal[scp_pkg::CTRL_DDR]            = rp.ddr;
            rdVal[scp_pkg::CTRL_READ_WAIT]      = rp.readWait;
            rdVal[scp_pkg::CTRL_SDIO_IRQ]       = rp.sdioIrqEn;
            rdVal[scp_pkg::CTRL_GRADE_LSB +: 2] = rp.grade;
        end else if (portSpace && regOff == scp_pkg::OFF_STAT[3:0]) begin
            rdVal[scp_pkg::STAT_DAT3]      = rp.dat3Deb;
            rdVal[scp_pkg::STAT_SWITCH]    = (q_ff.owner == portSel) && !q_ff.insDeb;
            rdVal[scp_pkg::STAT_WP]        = !rp.wpDeb;
            rdVal[scp_pkg::STAT_CLK_RUN]   = clkRun[portSel];
            rdVal[scp_pkg::STAT_GRADE_REJ] = gradeRej[portSel];
            rdVal[scp_pkg::STAT_DAT1]      = rp.syncB.dat1;
        end else if (apbReq.paddr == scp_pkg::ADDR_INT_STAT) begin
            rdVal[scp_pkg::INT_W-1:0] = q_ff.intStat;
        end else if (apbReq.paddr == scp_pkg::ADDR_INT_MASK) begin
            rdVal[scp_pkg::INT_W-1:0] = q_ff.intMask;
        end else if (apbReq.paddr == scp_pkg::ADDR_CFG) begin
            rdVal[scp_pkg::CFG_REF_LSB +: 2] = q_ff.refSel;
            rdVal[scp_pkg::CFG_OWNER]        = q_ff.owner;
        end
        if (apbSetup) begin
            nxt_q.prdata = rdVal;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            q_ff <= '0;
            for (int p = 0; p < scp_pkg::NPORT; p++) begin
                q_ff.port[p].div <= scp_pkg::INIT_DIV;
            end
            // Insert path starts at the switch's idle level, so reset raises no event
            q_ff.insA    <= 1'b1;
            q_ff.insB    <= 1'b1;
            q_ff.insDeb  <= 1'b1;
            q_ff.refSel  <= scp_pkg::RST_REF;
            q_ff.intMask <= scp_pkg::RST_INT_MASK;
        end else begin
            q_ff <= nxt_q;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign apbRsp.prdata  = q_ff.prdata;
    assign apbRsp.pready  = 1'b1;
    // Unmapped addresses flag an error only in the access phase
    assign apbRsp.pslverr = apbReq.psel && apbReq.penable && !apbHit;
    assign irq            = q_ff.irq;

    for (genvar g = 0; g < scp_pkg::NPORT; g++) begin : gen_port_out
        assign cardClockOut[g] = q_ff.port[g].clkLvl;
        assign dataStrobe[g]   = q_ff.port[g].strobe;
        assign ddrMode[g]      = q_ff.port[g].ddr;
        // Read-wait: host holds data line 2 low between blocks
        assign dat2Oe[g]       = q_ff.port[g].readWait;
        assign dat2Out[g]      = 1'b0;
        assign wpGpio[g]       = !q_ff.port[g].wpDeb;
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    AST_CLK_STOP_FULL: assert property (
        (rxBufFull[0] && !cardClockOut[0]) |=> !cardClockOut[0])
        else $error("card clock rose while receive buffer full");

    AST_CLK_STOP_EN: assert property (
        (!q_ff.port[1].clkEn && !cardClockOut[1]) |=> !cardClockOut[1])
        else $error("card clock rose while disabled");

    AST_DIV_HIGH_TIME: assert property (
        ($rose(cardClockOut[0]) && q_ff.port[0].grade == scp_pkg::GRADE_DIV
         && !q_ff.port[0].ddr && q_ff.port[0].div == 8'h02
         && $stable(q_ff.port[0].div)) |-> cardClockOut[0] [*3] ##1 !cardClockOut[0])
        else $error("card clock high phase differs from divisor");

    AST_G48_REJECT: assert property (
        (q_ff.port[0].grade == scp_pkg::GRADE_48
         && (q_ff.refSel == scp_pkg::REF_26M || q_ff.refSel == scp_pkg::REF_52M))
        |-> gradeRej[0])
        else $error("48 MHz grade accepted with wrong reference");

    AST_G52_REJECT: assert property (
        (q_ff.port[0].grade == scp_pkg::GRADE_52
         && (q_ff.refSel == scp_pkg::REF_19M2 || q_ff.refSel == scp_pkg::REF_38M4))
        |-> gradeRej[0])
        else $error("52 MHz grade accepted with wrong reference");

    AST_DDR_FALL_STROBE: assert property (
        $fell(cardClockOut[0]) |-> dataStrobe[0] == $past(q_ff.port[0].ddr))
        else $error("falling-edge data strobe does not follow DDR mode");

    AST_DAT3_EVENT: assert property (
        $changed(q_ff.port[0].dat3Deb) |-> q_ff.intStat[scp_pkg::EV_DAT3])
        else $error("data line 3 change did not set status");

    AST_SWITCH_OWNER: assert property (
        ($changed(q_ff.insDeb) && $past(q_ff.owner) == 1'b1)
        |-> q_ff.intStat[scp_pkg::EV_PER_PORT + scp_pkg::EV_SWITCH]
            && !$rose(q_ff.intStat[scp_pkg::EV_SWITCH]))
        else $error("switch event went to the wrong port");

    AST_WP_DEBOUNCE: assert property (
        $changed(q_ff.port[0].syncB.wp) |=> $stable(wpGpio[0]))
        else $error("write-protect output followed an unfiltered change");

    AST_SDIO_IRQ: assert property (
        (q_ff.port[0].sdioIrqEn && !q_ff.port[0].syncB.dat1)
        |=> q_ff.intStat[scp_pkg::EV_SDIO] && (irq || !q_ff.intMask[scp_pkg::EV_SDIO]))
        else $error("SDIO interrupt not captured");

    AST_READ_WAIT: assert property (
        $rose(q_ff.port[0].readWait) |-> dat2Oe[0] && !dat2Out[0])
        else $error("read-wait not driving data line 2 low");

    AST_STROBE_RISE: assert property (
        $rose(cardClockOut[0]) |-> dataStrobe[0])
        else $error("no data strobe on rising card clock edge");

    // Status is sticky: only a write to the status register may drop it
    AST_DAT3_STICKY: assert property (
        (q_ff.intStat[scp_pkg::EV_DAT3]
         && !(apbWrite && apbReq.paddr == scp_pkg::ADDR_INT_STAT))
        |=> q_ff.intStat[scp_pkg::EV_DAT3])
        else $error("data line 3 status dropped without a clear");

    // A filter must swallow any change that has not yet stood for two cycles
    AST_WP1_DEBOUNCE: assert property (
        $changed(q_ff.port[1].syncB.wp) |=> $stable(wpGpio[1]))
        else $error("write-protect output followed an unfiltered change");

    AST_DAT3_DEBOUNCE: assert property (
        $changed(q_ff.port[0].syncB.dat3) |=> $stable(q_ff.port[0].dat3Deb))
        else $error("data line 3 level followed an unfiltered change");

    AST_INS_DEBOUNCE: assert property (
        $changed(q_ff.insB) |=> $stable(q_ff.insDeb))
        else $error("insert switch level followed an unfiltered change");

endmodule : scp_storage_port

// ### testbench/scp_card_model.sv
`timescale 1ns/10ps
module scp_card_model (
    input  wire logic                  present,
    input  wire logic                  wpOn,
    input  wire logic                  sdioInt,
    output      scp_pkg::scp_card_in_t pins
);
    // Card pull-up wins over the board pull-down only while seated
    assign pins.dat3 = present;
    // Switches close to ground when active
    assign pins.wp = !wpOn;
    // Line 1 pulled up unless the card signals an interrupt
    assign pins.dat1 = !(present && sdioInt);
endmodule : scp_card_model

// ### testbench/tb.sv
`timescale 1ns/10ps
module tb;
    logic                        core_clk = 1'b0;
    logic                        arst_n   = 1'b0;
    scp_pkg::scp_apb_req_t       req      = '0;
    scp_pkg::scp_apb_rsp_t       rsp;
    scp_pkg::scp_card_in_t [1:0] pins;
    logic [1:0]                  present  = 2'h0;
    logic [1:0]                  wpOn     = 2'h0;
    logic [1:0]                  sdioInt  = 2'h0;
    logic [1:0]                  rxFull   = 2'h0;
    logic                        insSw    = 1'b1;
    logic [1:0]                  cko;
    logic [1:0]                  dat2Oe;
    logic [1:0]                  wpGpio;
    logic [1:0]                  ddrMode;
    logic [1:0]                  stb;
    logic [1:0]                  dat2O;
    logic                        irq;
    logic [31:0]                 q;
    logic                        err;
    int                          n_mismatch = 0;
    int                          n_checks   = 0;
    int                          n;

    always #5 core_clk = ~core_clk;

    scp_storage_port #(.DEB_CYCLES(4)) uut (.core_clk(core_clk), .arst_n(arst_n),
        .apbReq(req), .apbRsp(rsp), .cardIn(pins), .cardInsertSwitch(insSw),
        .rxBufFull(rxFull), .cardClockOut(cko), .dataStrobe(stb), .ddrMode(ddrMode),
        .dat2Out(dat2O), .dat2Oe(dat2Oe), .wpGpio(wpGpio), .irq(irq));

    for (genvar i = 0; i < 2; i++) begin : g_card
        scp_card_model card (.present(present[i]), .wpOn(wpOn[i]),
            .sdioInt(sdioInt[i]), .pins(pins[i]));
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task finish_test;
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Starts one edge on so a released strobe is never raised in the same step
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        req <= '{1'b1, 1'b0, wr, a, d};
        @(posedge core_clk);
        req.penable <= 1'b1;
        @(posedge core_clk);
        while (rsp.pready !== 1'b1) @(posedge core_clk);
        q = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb

    task rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, q & m);
    endtask : rdc

    // Cycles of one full high phase of port zero's card clock
    task hiLen;
        n = 0;
        repeat (60) if (cko[0] !== 1'b0) @(posedge core_clk);
        repeat (60) if (cko[0] !== 1'b1) @(posedge core_clk);
        while (cko[0] === 1'b1 && n < 60) begin
            n++;
            @(posedge core_clk);
        end
    endtask : hiLen

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        rdc("div0", scp_pkg::OFF_DIV, 32'hFF, 32'(scp_pkg::INIT_DIV));
        apb(1'b0, 8'h30, 32'h0);
        chk("pslverr", 32'h1, 32'(err));
        present[0] <= 1'b1;
        repeat (20) @(posedge core_clk);
        rdc("dat3 event", scp_pkg::ADDR_INT_STAT, 32'h3F, 32'h01);
        chk("irq masked", 32'h0, 32'(irq));
        apb(1'b1, scp_pkg::ADDR_INT_MASK, 32'h3F);
        repeat (2) @(posedge core_clk);
        chk("irq", 32'h1, 32'(irq));
        apb(1'b1, scp_pkg::ADDR_INT_STAT, 32'h3F);
        repeat (2) @(posedge core_clk);
        chk("irq cleared", 32'h0, 32'(irq));
        apb(1'b1, scp_pkg::ADDR_CFG, 32'h4);
        insSw <= 1'b0;
        repeat (20) @(posedge core_clk);
        rdc("switch event", scp_pkg::ADDR_INT_STAT, 32'h3F, 32'h10);
        rdc("owner present", 8'h18, 32'h2, 32'h2);
        rdc("other present", scp_pkg::OFF_STAT, 32'h2, 32'h0);
        apb(1'b1, scp_pkg::ADDR_INT_STAT, 32'h3F);
        wpOn[1] <= 1'b1;
        repeat (20) @(posedge core_clk);
        chk("wp gpio", 32'h2, 32'(wpGpio));
        apb(1'b1, scp_pkg::OFF_DIV, 32'h2);
        apb(1'b1, scp_pkg::OFF_CTRL, 32'h1);
        hiLen;
        chk("high div2", 32'h3, 32'(n));
        rxFull[0] <= 1'b1;
        repeat (12) @(posedge core_clk);
        n = 0;
        repeat (10) begin
            @(posedge core_clk);
            if (cko[0] !== 1'b0) n++;
        end
        chk("stopped", 32'h0, 32'(n));
        rxFull[0] <= 1'b0;
        n = 0;
        while (cko[0] !== 1'b1 && n < 20) begin
            n++;
            @(posedge core_clk);
        end
        chk("restart", 32'h1, 32'(n < 6));
        apb(1'b1, scp_pkg::OFF_CTRL, 32'h11);
        rdc("g48 ref ok", scp_pkg::OFF_STAT, 32'h10, 32'h0);
        apb(1'b1, scp_pkg::ADDR_CFG, 32'h5);
        rdc("g48 ref bad", scp_pkg::OFF_STAT, 32'h10, 32'h10);
        apb(1'b1, scp_pkg::OFF_CTRL, 32'h21);
        rdc("g52 ref ok", scp_pkg::OFF_STAT, 32'h10, 32'h0);
        hiLen;
        chk("high g52", 32'h1, 32'(n));
        apb(1'b1, scp_pkg::ADDR_CFG, 32'h4);
        rdc("g52 ref bad", scp_pkg::OFF_STAT, 32'h10, 32'h10);
        apb(1'b1, scp_pkg::OFF_CTRL, 32'h0F);
        sdioInt[0] <= 1'b1;
        repeat (6) @(posedge core_clk);
        chk("ddr", 32'h1, 32'(ddrMode[0]));
        chk("read wait", 32'h1, 32'(dat2Oe[0]));
        chk("dat2 low", 32'h0, 32'(dat2O[0]));
        n = 0;
        repeat (12) @(posedge core_clk) if (stb[0] === 1'b1) n++;
        chk("ddr strobes", 32'h4, 32'(n));
        rdc("sdio event", scp_pkg::ADDR_INT_STAT, 32'h4, 32'h4);
        finish_test;
    end

    initial begin
        #100000;
        n_mismatch++;
        finish_test;
    end
endmodule : tb
